// File: rtl/rsrc_ctrl.sv
// Contract
// R1: Processor programs select field before reading.
// R2: Command write starts read transaction.
// R3: Completion clears command bits, loads buffer.
// R4: Parity error flag updated each read.
// R5: Command write while pending is ignored; bits 6:5 still write the parity flags.
// R6: Processor polls command bits until zero.
// R7: With engine on, write after pass edge.
// R8: Write lands before next frame sync edge.
// R9: Bits 4:2 command, bits 1:0 phase.
// R10: Only codes 001, 010 start reads.
// R11: Phase picks input pair and select field.
// R12: Trim byte: bit7 to 8, 6:0 to 7:1.
// R13: Bandgap B high byte, D low byte.
// R14: Temperature eleven bits, sign extended.
// R15: Supply in low byte, version high byte.
// R16: Parity flag sticky until processor clears.
// R17: Command bits read busy while pending.
// R18: Sensor link is request/acknowledge port.
module rsrc_ctrl
   import rsrc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        clk_en_i,
   // Processor register port
   input  wire logic [15:0] reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [7:0]  reg_wdata_i,
   output logic      [7:0]  reg_rdata_o,
   // Sensor link
   output logic             link_req_o,
   output logic      [1:0]  link_phase_o,
   output logic      [2:0]  link_cmd_o,
   output logic      [2:0]  link_sel_o,
   input  wire logic        link_ack_i,
   input  wire logic [15:0] link_data_i,
   input  wire logic        link_perr_i
);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   // Only two command codes do anything; all others are dropped
   function automatic logic rsrc_cmd_ok(input logic [2:0] c);
      return (c == RSRC_CMD_ONE) || (c == RSRC_CMD_TWO);
   endfunction

   // Phase code picks one of the three select fields
   function automatic logic [2:0] rsrc_sel_of(input logic [1:0] ph,
                                              input logic [7:0] s12,
                                              input logic [7:0] s3);
      logic [2:0] r;
      r = 3'h0;
      unique case (ph)
         RSRC_PH_FIRST:  r = s12[2:0];
         RSRC_PH_SECOND: r = s12[RSRC_SEL2_LSB +: 3];
         RSRC_PH_THIRD:  r = s3[2:0];
         default:        r = 3'h0;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   rsrc_state_type state_r;
   logic [2:0]     cmd_r;
   logic [1:0]     phase_r;
   logic           perr_r;
   logic           perr_wr_r;
   logic [7:0]     sel12_r;
   logic [7:0]     sel3_r;
   logic [15:0]    rdbuf_r;
   logic [15:0]    fmt_nxt;

   logic wr_cmd;
   logic start;
   assign wr_cmd = clk_en_i && reg_wr_i && (reg_addr_i == RSRC_ADDR_CMD);
   // Start only from idle with a valid command and phase [R2] [R5] [R10]
   assign start  = wr_cmd && (state_r == RSRC_IDLE) &&
                   rsrc_cmd_ok(reg_wdata_i[4:2]) &&
                   (reg_wdata_i[1:0] != RSRC_PH_NONE);   // [R11]

   // ----------------------------------------------------------------
   // Select registers
   // ----------------------------------------------------------------
   // Processor owns these; sel12_r drops bits 7 and 3, sel3_r keeps its unused bits [R1]
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel12_r <= RSRC_RST_BYTE;
         sel3_r  <= RSRC_RST_BYTE;
      end else if (clk_en_i && reg_wr_i) begin
         if (reg_addr_i == RSRC_ADDR_SEL12)
            sel12_r <= reg_wdata_i & 8'h77;
         if (reg_addr_i == RSRC_ADDR_SEL3)
            sel3_r <= reg_wdata_i;
      end
   end

   // ----------------------------------------------------------------
   // Transaction sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= RSRC_IDLE;
      end else if (clk_en_i) begin
         unique case (state_r)
            RSRC_IDLE: if (start) state_r <= RSRC_REQ;
            RSRC_REQ:  if (link_ack_i) state_r <= RSRC_DONE;
            RSRC_DONE: state_r <= RSRC_IDLE;
            default:   state_r <= RSRC_IDLE;
         endcase
      end
   end

   // Command bits stay non-zero while busy, cleared at done [R3] [R17]
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd_r   <= 3'h0;
         phase_r <= RSRC_PH_NONE;
      end else if (clk_en_i) begin
         if (start) begin
            cmd_r   <= reg_wdata_i[4:2];                  // [R9]
            phase_r <= reg_wdata_i[1:0];                  // [R9]
         end else if (state_r == RSRC_REQ && link_ack_i) begin
            cmd_r   <= 3'h0;                              // [R3]
         end
      end
   end

   // Link request held until acknowledge [R18]
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         link_req_o   <= 1'b0;
         link_phase_o <= RSRC_PH_NONE;
         link_cmd_o   <= 3'h0;
         link_sel_o   <= 3'h0;
      end else if (clk_en_i) begin
         if (start) begin
            link_req_o   <= 1'b1;
            link_phase_o <= reg_wdata_i[1:0];
            link_cmd_o   <= reg_wdata_i[4:2];
            // Select sampled at start; later edits do not disturb it
            link_sel_o   <= rsrc_sel_of(reg_wdata_i[1:0], sel12_r, sel3_r);
         end else if (link_ack_i) begin
            link_req_o   <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Result formatting
   // ----------------------------------------------------------------
   // Raw sensor fields sit low-aligned in link_data_i
   always_comb begin
      fmt_nxt = link_data_i;
      if (link_cmd_o == RSRC_CMD_ONE) begin
         unique case (link_sel_o[2:1])
            RSRC_SEL_TRIM:
               fmt_nxt = {7'h00, link_data_i[7:0], 1'b0};  // [R12]
            RSRC_SEL_BANDGAP:
               fmt_nxt = link_data_i;                      // [R13]
            default: fmt_nxt = link_data_i;
         endcase
      end else begin
         unique case (link_sel_o[2:1])
            RSRC_SEL_TRIM:                                 // [R14]
               fmt_nxt = {{5{link_data_i[10]}}, link_data_i[10:0]};
            RSRC_SEL_SUPPLY:
               fmt_nxt = {8'h00, link_data_i[7:0]};        // [R15]
            RSRC_SEL_VERSION:
               fmt_nxt = {link_data_i[7:0], 8'h00};        // [R15]
            default: fmt_nxt = link_data_i;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdbuf_r <= RSRC_RST_WORD;
      end else if (clk_en_i && state_r == RSRC_REQ && link_ack_i) begin
         rdbuf_r <= fmt_nxt;                               // [R3]
      end
   end

   // ----------------------------------------------------------------
   // Parity flags
   // ----------------------------------------------------------------
   // Set wins over a same-cycle clear so no error is lost [R4] [R16]
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         perr_r    <= 1'b0;
         perr_wr_r <= 1'b0;
      end else if (clk_en_i) begin
         if (state_r == RSRC_REQ && link_ack_i && link_perr_i)
            perr_r <= 1'b1;
         else if (wr_cmd)
            perr_r <= reg_wdata_i[RSRC_PERR_BIT];
         if (wr_cmd)
            perr_wr_r <= reg_wdata_i[RSRC_PERR_BIT-1];
      end
   end

   // ----------------------------------------------------------------
   // Read data, registered
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= RSRC_RST_BYTE;
      end else if (clk_en_i && reg_rd_i) begin
         unique case (reg_addr_i)
            RSRC_ADDR_CMD:
               reg_rdata_o <= {1'b0, perr_r, perr_wr_r, cmd_r, phase_r};
            RSRC_ADDR_RD_HI: reg_rdata_o <= rdbuf_r[15:8];
            RSRC_ADDR_RD_LO: reg_rdata_o <= rdbuf_r[7:0];
            RSRC_ADDR_SEL3:  reg_rdata_o <= sel3_r;
            RSRC_ADDR_SEL12: reg_rdata_o <= sel12_r;
            default:         reg_rdata_o <= RSRC_RST_BYTE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   busy_write_a: assert property ( // [R5]
      @(posedge clk_i) disable iff (!rst_n_i)
      (state_r != RSRC_IDLE && wr_cmd) |=> $stable(link_cmd_o))
      else $error("command write while busy changed request");
   invalid_cmd_a: assert property ( // [R10]
      @(posedge clk_i) disable iff (!rst_n_i)
      (wr_cmd && !rsrc_cmd_ok(reg_wdata_i[4:2]) && state_r == RSRC_IDLE)
      |=> !link_req_o)
      else $error("invalid command started a read");
   bad_phase_a: assert property ( // [R11]
      @(posedge clk_i) disable iff (!rst_n_i)
      (wr_cmd && reg_wdata_i[1:0] == RSRC_PH_NONE) |=> !$rose(link_req_o))
      else $error("phase zero started a read");
   start_req_a: assert property ( // [R2]
      @(posedge clk_i) disable iff (!rst_n_i)
      start |=> link_req_o && cmd_r == link_cmd_o)
      else $error("start did not raise request");
   done_clear_a: assert property ( // [R3]
      @(posedge clk_i) disable iff (!rst_n_i)
      (clk_en_i && state_r == RSRC_REQ && link_ack_i)
      |=> cmd_r == 3'h0 && rdbuf_r == $past(fmt_nxt))
      else $error("completion did not clear command or load buffer");
   busy_shown_a: assert property ( // [R17]
      @(posedge clk_i) disable iff (!rst_n_i)
      (state_r == RSRC_REQ) |-> cmd_r != 3'h0)
      else $error("command bits zero while pending");
   perr_sticky_a: assert property ( // [R16]
      @(posedge clk_i) disable iff (!rst_n_i)
      (perr_r && !wr_cmd) |=> perr_r)
      else $error("parity flag dropped without clear");
   perr_set_a: assert property ( // [R4]
      @(posedge clk_i) disable iff (!rst_n_i)
      (clk_en_i && state_r == RSRC_REQ && link_ack_i && link_perr_i)
      |=> perr_r)
      else $error("parity error not flagged");
   // Judged on the stored buffer, not on the formatter that feeds it
   temp_sign_a: assert property ( // [R14]
      @(posedge clk_i) disable iff (!rst_n_i)
      (clk_en_i && state_r == RSRC_REQ && link_ack_i &&
       link_cmd_o == RSRC_CMD_TWO && link_sel_o[2:1] == RSRC_SEL_TRIM)
      |=> rdbuf_r[15:11] == {5{rdbuf_r[10]}})
      else $error("temperature not sign extended");
   // Select cannot be written in the start cycle, so it is still there
   sel_route_a: assert property ( // [R1] [R9]
      @(posedge clk_i) disable iff (!rst_n_i)
      (start && reg_wdata_i[1:0] == RSRC_PH_THIRD)
      |=> link_sel_o == sel3_r[2:0])
      else $error("third pair select not routed");

   read_done_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      start ##[1:20] (state_r == RSRC_DONE));
   busy_ignore_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_r == RSRC_REQ && wr_cmd));
   perr_seen_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(perr_r));

endmodule // rsrc_ctrl

// File: rtl/rsrc_pkg.sv
package rsrc_pkg;
   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] RSRC_ADDR_CMD     = 16'h00fc;
   localparam logic [15:0] RSRC_ADDR_RD_HI   = 16'h2602;
   localparam logic [15:0] RSRC_ADDR_RD_LO   = 16'h2603;
   localparam logic [15:0] RSRC_ADDR_SEL3    = 16'h2709;
   localparam logic [15:0] RSRC_ADDR_SEL12   = 16'h270a;
   // ----------------------------------------------------------------
   // Field positions and codes
   // ----------------------------------------------------------------
   localparam int          RSRC_PERR_BIT     = 6;
   localparam int          RSRC_SEL2_LSB     = 4;
   localparam logic [2:0]  RSRC_CMD_ONE      = 3'h1;
   localparam logic [2:0]  RSRC_CMD_TWO      = 3'h2;
   localparam logic [1:0]  RSRC_PH_NONE      = 2'h0;
   localparam logic [1:0]  RSRC_PH_FIRST     = 2'h1;
   localparam logic [1:0]  RSRC_PH_SECOND    = 2'h2;
   localparam logic [1:0]  RSRC_PH_THIRD     = 2'h3;
   localparam logic [1:0]  RSRC_SEL_TRIM     = 2'h0;
   localparam logic [1:0]  RSRC_SEL_SUPPLY   = 2'h1;
   localparam logic [1:0]  RSRC_SEL_VERSION  = 2'h2;
   localparam logic [1:0]  RSRC_SEL_BANDGAP  = 2'h3;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  RSRC_RST_BYTE     = 8'h00;
   localparam logic [15:0] RSRC_RST_WORD     = 16'h0000;
   // ----------------------------------------------------------------
   // Controller states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RSRC_IDLE = 2'b00,
      RSRC_REQ  = 2'b01,
      RSRC_DONE = 2'b11
   } rsrc_state_type;
endpackage

// File: verif/rsrc_sensor_model.sv
// ----------------------------------------------------------------
// Remote sensor stand-in
// ----------------------------------------------------------------
module rsrc_sensor_model (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        req_i,
   input  wire logic [7:0]  delay_i,
   input  wire logic [15:0] raw_i,
   input  wire logic        perr_i,
   output logic             ack_o,
   output logic      [15:0] data_o,
   output logic             perr_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] wait_r;
   // Ack after delay_i cycles; data toggles when not valid
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_r <= 8'h00;
         ack_o  <= 1'b0;
         data_o <= 16'h0000;
         perr_o <= 1'b0;
      end else begin
         ack_o  <= 1'b0;
         data_o <= ~data_o;
         perr_o <= ~perr_o;
         if (req_i && !ack_o) begin
            if (wait_r == delay_i) begin
               ack_o  <= 1'b1;
               data_o <= raw_i;
               perr_o <= perr_i;
               wait_r <= 8'h00;
            end else begin
               wait_r <= wait_r + 8'h01;
            end
         end
      end
   end
endmodule // rsrc_sensor_model

// File: verif/rsrc_ctrl_tb_top.sv
module rsrc_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import rsrc_pkg::*;
   logic        clk_i, rst_n_i, clk_en_i, reg_wr_i, reg_rd_i;
   logic        link_req_o, link_ack_i, link_perr_i, m_perr, keep_perr;
   logic [15:0] reg_addr_i, link_data_i, m_raw;
   logic [7:0]  reg_wdata_i, reg_rdata_o, m_dly;
   logic [2:0]  link_cmd_o, link_sel_o;
   logic [1:0]  link_phase_o;
   int          failures, compares;
   // Table of {cmd, phase, select}, raw word, expected buffer
   localparam logic [7:0]  CPS [6] = '{8'h28, 8'h37, 8'h59,
                                       8'h48, 8'h53, 8'h5d};
   localparam logic [15:0] RAW [6] = '{16'h00a5, 16'h3c96, 16'h0400,
                                       16'h03ff, 16'h5a7e, 16'h0033};
   localparam logic [15:0] EXP [6] = '{16'h014a, 16'h3c96, 16'hfc00,
                                       16'h03ff, 16'h007e, 16'h3300};
   rsrc_ctrl u_rsrc_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .link_req_o(link_req_o),
      .link_phase_o(link_phase_o), .link_cmd_o(link_cmd_o),
      .link_sel_o(link_sel_o), .link_ack_i(link_ack_i),
      .link_data_i(link_data_i), .link_perr_i(link_perr_i));
   rsrc_sensor_model u_rsrc_sensor_model (.clk_i(clk_i),
      .rst_n_i(rst_n_i), .req_i(link_req_o), .delay_i(m_dly),
      .raw_i(m_raw), .perr_i(m_perr), .ack_o(link_ack_i),
      .data_o(link_data_i), .perr_o(link_perr_i));
   // ----------------------------------------------------------------
   // Clock and shared tasks
   // ----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #5;
      reg_addr_i  = a;
      reg_wdata_i = d;
      reg_wr_i    = 1'b1;
      @(posedge clk_i);
      #5;
      reg_wr_i = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_i);
      #5;
      reg_addr_i = a;
      reg_rd_i   = 1'b1;
      @(posedge clk_i);
      #5;
      reg_rd_i = 1'b0;
      d        = reg_rdata_o;
   endtask
   // Unused fields get the inverse so a wrong field pick shows
   task automatic issue(input logic [2:0] c, input logic [1:0] p,
                        input logic [2:0] s);
      logic [2:0] f1, f2, f3;
      f1 = (p == 2'h1) ? s : ~s;
      f2 = (p == 2'h2) ? s : ~s;
      f3 = (p == 2'h3) ? s : ~s;
      wr(RSRC_ADDR_SEL12, {1'b0, f2, 1'b0, f1});
      wr(RSRC_ADDR_SEL3, {5'h00, f3});
      // Engine held off here, so no pass-edge window to meet
      // Bit 6 written as keep_perr: a zero there would clear the flag
      wr(RSRC_ADDR_CMD, {1'b0, keep_perr, 1'b0, c, p});
      chk({7'h0, link_req_o, link_cmd_o, link_phase_o, link_sel_o},
          {7'h0, 1'b1, c, p, s});
   endtask
   task automatic finish(input logic [15:0] ex, input logic ep);
      logic [7:0] d, h, l;
      int         n;
      d = 8'hff;
      n = 0;
      while (d[4:2] !== 3'h0 && n < 200) begin
         rd(RSRC_ADDR_CMD, d);
         n++;
      end
      chk({12'h0, link_req_o, d[4:2]}, 16'h0000);
      chk({15'h0, d[6]}, {15'h0, ep});
      rd(RSRC_ADDR_RD_HI, h);
      rd(RSRC_ADDR_RD_LO, l);
      chk({h, l}, ex);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      logic [15:0] a [6] = '{RSRC_ADDR_CMD, RSRC_ADDR_RD_HI,
         RSRC_ADDR_RD_LO, RSRC_ADDR_SEL3, RSRC_ADDR_SEL12, 16'h1234};
      logic [7:0]  d;
      foreach (a[i]) begin
         rd(a[i], d);
         chk({8'h0, d}, 16'h0000);
      end
      wr(RSRC_ADDR_RD_HI, 8'hff);
      rd(RSRC_ADDR_RD_HI, d);
      chk({8'h0, d}, 16'h0000);
      wr(RSRC_ADDR_SEL12, 8'hff);
      rd(RSRC_ADDR_SEL12, d);
      chk({8'h0, d}, 16'h0077);
      $display("reset test done");
   endtask
   // Every command, phase and select group, prompt and slow answers
   task automatic t_formats;
      for (int i = 0; i < 6; i++) begin
         m_dly = 8'(i * 3);
         m_raw = RAW[i];
         issue(CPS[i][7:5], CPS[i][4:3], CPS[i][2:0]);
         finish(EXP[i], 1'b0);
      end
      $display("format test done");
   endtask
   task automatic t_busy;
      logic [7:0] d;
      m_dly = 8'd20;
      m_raw = 16'h0011;
      issue(3'h1, 2'h1, 3'h0);
      wr(RSRC_ADDR_CMD, 8'h0b);
      chk({11'h0, link_cmd_o, link_phase_o}, 16'h0005);
      rd(RSRC_ADDR_CMD, d);
      chk({11'h0, d[4:0]}, 16'h0005);
      finish(16'h0022, 1'b0);
      $display("busy test done");
   endtask
   task automatic t_perr;
      logic [7:0] d;
      m_dly  = 8'd2;
      m_raw  = 16'h0044;
      m_perr = 1'b1;
      issue(3'h2, 2'h2, 3'h2);
      finish(16'h0044, 1'b1);
      m_perr = 1'b0;
      keep_perr = 1'b1;
      issue(3'h2, 2'h2, 3'h2);
      keep_perr = 1'b0;
      finish(16'h0044, 1'b1);
      wr(RSRC_ADDR_CMD, 8'h00);
      rd(RSRC_ADDR_CMD, d);
      chk({15'h0, d[6]}, 16'h0000);
      wr(RSRC_ADDR_CMD, 8'h20);
      rd(RSRC_ADDR_CMD, d);
      chk({14'h0, d[6:5]}, 16'h0001);
      wr(RSRC_ADDR_CMD, 8'h00);
      $display("parity test done");
   endtask
   // Refused codes, and a write while the clock enable is low
   task automatic t_refuse;
      logic [7:0] c [3] = '{8'h01, 8'h15, 8'h04};
      foreach (c[i]) begin
         wr(RSRC_ADDR_CMD, c[i]);
         repeat (3) @(posedge clk_i);
         chk({15'h0, link_req_o}, 16'h0000);
      end
      @(posedge clk_i);
      #5;
      clk_en_i = 1'b0;
      wr(RSRC_ADDR_CMD, 8'h05);
      clk_en_i = 1'b1;
      repeat (3) @(posedge clk_i);
      chk({15'h0, link_req_o}, 16'h0000);
      $display("refuse test done");
   endtask
   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      {rst_n_i, reg_wr_i, reg_rd_i, m_perr, keep_perr} = 5'h00;
      {clk_en_i, reg_addr_i, reg_wdata_i} = 25'h1000000;
      {m_dly, m_raw, failures, compares} = '0;
      repeat (20) @(posedge clk_i);
      #5;
      rst_n_i = 1'b1;
      t_reset();
      t_formats();
      t_busy();
      t_perr();
      t_refuse();
      tally_and_finish();
   end
   // Runs far longer than all scenarios need
   initial begin
      #(5000 * 50);
      failures++;
      tally_and_finish();
   end
endmodule // rsrc_ctrl_tb_top
